// ===== logic/bla_map.vh
// Purpose: constants of the boot loader addressing block
// Assumes: 10 MHz core clock, 32-bit control word, 100 kHz serial bus
// Notes:   control word fields are given as little-endian bit numbers
`ifndef BLA_MAP_VH
`define BLA_MAP_VH

// register offsets
`define BLA_OFS_CTRL 8'h00
`define BLA_OFS_STAT 8'h04

// control word fields
`define BLA_B_CHAIN 31
`define BLA_B_OFFSET_BYTE_COUNT_SEL 30
`define BLA_B_SLAVE_ID_WRAP_INCREMENT 29
`define BLA_B_UNLK 28
`define BLA_F_BADDR 22:16
`define BLA_F_BADDR_HI 22:18
`define BLA_F_BADDR_LO 17:16
`define BLA_F_PMODE 15:13
`define BLA_F_PADDR 12:0

// status word fields
`define BLA_B_BUSY 31
`define BLA_B_DONE 30
`define BLA_B_ERR 29
`define BLA_F_DEV 22:16
`define BLA_F_ADDR 15:0

// reset values
`define BLA_RST_BADDR_HI 5'h14
`define BLA_RST_OFFSET_BYTE_COUNT_SEL 1'b0
`define BLA_RST_SLAVE_ID_WRAP_INCREMENT 1'b1
`define BLA_RST_PMODE 3'h0
`define BLA_RST_PADDR 13'h0000

// page mode with no boundary, fixed low address bits
`define BLA_PM_INF 3'h7
`define BLA_PADDR_LSB 3'h0

// serial engine commands
`define BLA_CMD_START 2'h0
`define BLA_CMD_STOP 2'h1
`define BLA_CMD_WR 2'h2
`define BLA_CMD_RD 2'h3

// timing
`define BLA_SYS_NS 100
`define BLA_SCL_NS 10000
`define BLA_QTR_CYC (`BLA_SCL_NS / `BLA_SYS_NS / 4)
`define BLA_STRAP_WAIT 2'h3

`endif

// ===== logic/bla_sync.v
// Purpose: two-stage synchroniser for pins
// Assumes: inputs are asynchronous to sys_clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none

module bla_sync #(
  parameter W = 2
) (
  input wire sys_clk,
  input wire rst_b,
  input wire clk_en,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // two flip-flop stages per bit, frozen while clk_en is low
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else if (clk_en) begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule

`default_nettype wire

// ===== logic/bla_i2c_eng.v
// Purpose: byte level serial bus master (start, stop, write, read)
// Assumes: sda_s and scl_s already synchronised
// Notes:   each bit is four quarter periods; slave may stretch the clock
`timescale 1ns/1ns
`default_nettype none
`include "bla_map.vh"

module bla_i2c_eng (
  input wire sys_clk,
  input wire rst_b,
  input wire clk_en,
  input wire cmd_valid,
  input wire [1:0] cmd,
  input wire [7:0] tx_byte,
  input wire nack_out,
  input wire sda_s,
  input wire scl_s,
  output wire busy,
  output reg done_q,
  output wire [7:0] rx_byte,
  output reg rx_nack_q,
  output reg scl_oe_q,
  output reg sda_oe_q
);

  localparam integer QTR_LAST = `BLA_QTR_CYC - 1;

  reg busy_q;
  reg [1:0] cmd_q;
  reg [1:0] qtr_q;
  reg [3:0] bit_q;
  reg [6:0] cnt_q;
  reg [7:0] sh_q;
  reg nack_q;
  reg sda_lvl;
  reg scl_lvl;
  wire tick;
  wire stretch;

  // wanted line levels for the current quarter
  always @* begin
    sda_lvl = 1'b1;
    scl_lvl = qtr_q[0] ^ qtr_q[1];
    case (cmd_q)
      `BLA_CMD_START: sda_lvl = ~qtr_q[1];
      `BLA_CMD_STOP: begin
        sda_lvl = qtr_q[1];
        scl_lvl = |qtr_q;
      end
      `BLA_CMD_WR: sda_lvl = bit_q[3] | sh_q[7];
      default: sda_lvl = ~bit_q[3] | nack_q;
    endcase
  end

  // slave holding the clock low stalls the high quarter
  assign stretch = (qtr_q == 2'h1) & ~scl_s;
  assign tick = (cnt_q == QTR_LAST[6:0]) & ~stretch;

  // quarter sequencer, shifter and line drivers
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      cmd_q <= `BLA_CMD_STOP;
      qtr_q <= 2'h0;
      bit_q <= 4'h0;
      cnt_q <= 7'h00;
      sh_q <= 8'h00;
      nack_q <= 1'b0;
      done_q <= 1'b0;
      rx_nack_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= 1'b0;
      if (!busy_q) begin
        if (cmd_valid) begin
          busy_q <= 1'b1;
          cmd_q <= cmd;
          sh_q <= tx_byte;
          nack_q <= nack_out;
          qtr_q <= 2'h0;
          bit_q <= 4'h0;
          cnt_q <= 7'h00;
        end
      end else begin
        sda_oe_q <= ~sda_lvl;
        scl_oe_q <= ~scl_lvl;
        if (!tick) begin
          cnt_q <= (cnt_q == QTR_LAST[6:0]) ? cnt_q : cnt_q + 7'h01;
        end else begin
          cnt_q <= 7'h00;
          qtr_q <= qtr_q + 2'h1;
          if (qtr_q == 2'h2 && cmd_q == `BLA_CMD_RD && !bit_q[3])
            sh_q <= {sh_q[6:0], sda_s};
          if (qtr_q == 2'h2 && bit_q[3])
            rx_nack_q <= sda_s;
          if (qtr_q == 2'h3) begin
            bit_q <= bit_q + 4'h1;
            if (cmd_q == `BLA_CMD_WR && !bit_q[3])
              sh_q <= {sh_q[6:0], 1'b0};
            if (!cmd_q[1] || bit_q[3]) begin
              busy_q <= 1'b0;
              done_q <= 1'b1;
            end
          end
        end
      end
    end
  end

  assign busy = busy_q;
  assign rx_byte = sh_q;

endmodule

`default_nettype wire

// ===== logic/bla_top.v
// Purpose: addressing logic of the serial EEPROM boot loader
// Assumes: core clock sys_clk; loader logic reports load count and end
// Notes:   the device is bus master, the EEPROM is the slave
`timescale 1ns/1ns
`default_nettype none
`include "bla_map.vh"

module bla_top (
  input wire sys_clk,
  input wire rst_b,
  input wire clk_en,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [31:0] reg_rdata,
  input wire [1:0] slave_id_strap_pins,
  input wire load_cnt_zero,
  input wire load_stop,
  output wire [7:0] rx_data,
  output wire rx_valid,
  output wire boot_busy,
  output wire boot_done,
  output wire boot_err,
  input wire scl_in,
  output wire scl_out,
  output wire scl_oe,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe
);

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_START = 4'h1;
  localparam [3:0] ST_DEVW = 4'h2;
  localparam [3:0] ST_AHI = 4'h3;
  localparam [3:0] ST_ALO = 4'h4;
  localparam [3:0] ST_RSTRT = 4'h5;
  localparam [3:0] ST_DEVR = 4'h6;
  localparam [3:0] ST_READ = 4'h7;
  localparam [3:0] ST_STOP = 4'h8;
  localparam [3:0] ST_DONE = 4'h9;

  // control word
  reg chain_q;
  reg offset_byte_count_sel_q;
  reg slave_id_wrap_increment_q;
  reg unlk_q;
  reg [6:0] baddr_q;
  reg [2:0] pmode_q;
  reg [12:0] paddr_q;

  // working copies and sequencer
  reg [3:0] state_q;
  reg [1:0] strap_cnt_q;
  reg [6:0] dev_q;
  reg [15:0] addr_q;
  reg wpsize_q;
  reg wbinc_q;
  reg wait_q;
  reg last_q;
  reg keep_q;
  reg chain_pend_q;
  reg stop_pend_q;
  reg err_q;
  reg [7:0] rx_data_q;
  reg rx_valid_q;
  reg [31:0] rdata_q;

  // engine requests
  reg eng_go;
  reg [1:0] eng_cmd;
  reg [7:0] eng_tx;
  reg [15:0] nxt_addr;
  reg wrap_one;
  reg readdr;
  reg last_c;

  wire [1:0] pin_s;
  wire [1:0] strap_s;
  wire eng_busy;
  wire eng_done;
  wire [7:0] eng_rx;
  wire eng_rnack;
  wire active;
  wire ctrl_wr;
  wire strap_take;
  wire chain_set;
  wire chain_take;

  // offset boundary mask for each page mode
  function [15:0] page_mask;
    input [2:0] m;
    begin
      case (m)
        3'h0: page_mask = 16'h0007;
        3'h1: page_mask = 16'h001F;
        3'h2: page_mask = 16'h003F;
        3'h3: page_mask = 16'h007F;
        3'h4: page_mask = 16'h00FF;
        3'h5: page_mask = 16'h01FF;
        default: page_mask = 16'h03FF;
      endcase
    end
  endfunction

  // next offset; one-byte offsets wrap at 256
  function [15:0] addr_inc;
    input [15:0] a;
    input two;
    begin
      if (two)
        addr_inc = a + 16'h0001;
      else
        addr_inc = {8'h00, a[7:0] + 8'h01};
    end
  endfunction

  // start offset from the start field, shifted by three
  function [15:0] start_addr;
    input [12:0] f;
    input two;
    begin
      if (two)
        start_addr = {f, `BLA_PADDR_LSB};
      else
        start_addr = {8'h00, f[4:0], `BLA_PADDR_LSB};
    end
  endfunction

  // pins cross into the core clock
  bla_sync #(.W(2)) u_pin_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .d({scl_in, sda_in}),
    .q(pin_s)
  );

  bla_sync #(.W(2)) u_strap_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .d(slave_id_strap_pins),
    .q(strap_s)
  );

  bla_i2c_eng u_eng (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .cmd_valid(eng_go),
    .cmd(eng_cmd),
    .tx_byte(eng_tx),
    .nack_out(last_c),
    .sda_s(pin_s[0]),
    .scl_s(pin_s[1]),
    .busy(eng_busy),
    .done_q(eng_done),
    .rx_byte(eng_rx),
    .rx_nack_q(eng_rnack),
    .scl_oe_q(scl_oe),
    .sda_oe_q(sda_oe)
  );

  assign active = (state_q != ST_IDLE) && (state_q != ST_DONE);
  assign ctrl_wr = reg_wr && (reg_addr == `BLA_OFS_CTRL);
  assign strap_take = (state_q == ST_IDLE) && (strap_cnt_q == `BLA_STRAP_WAIT);
  assign chain_set = ctrl_wr & reg_wdata[`BLA_B_CHAIN] & load_cnt_zero & active;
  assign chain_take = (state_q == ST_READ) & eng_done & last_q & chain_pend_q;

  // control word: straps at power-up, bus writes after
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      chain_q <= 1'b0;
      offset_byte_count_sel_q <= `BLA_RST_OFFSET_BYTE_COUNT_SEL;
      slave_id_wrap_increment_q <= `BLA_RST_SLAVE_ID_WRAP_INCREMENT;
      unlk_q <= 1'b0;
      baddr_q <= {`BLA_RST_BADDR_HI, 2'h0};
      pmode_q <= `BLA_RST_PMODE;
      paddr_q <= `BLA_RST_PADDR;
    end else if (clk_en) begin
      if (strap_take)
        baddr_q[1:0] <= strap_s;
      if (ctrl_wr) begin
        chain_q <= reg_wdata[`BLA_B_CHAIN];
        offset_byte_count_sel_q <= reg_wdata[`BLA_B_OFFSET_BYTE_COUNT_SEL];
        slave_id_wrap_increment_q <= reg_wdata[`BLA_B_SLAVE_ID_WRAP_INCREMENT];
        unlk_q <= reg_wdata[`BLA_B_UNLK];
        baddr_q[6:2] <= reg_wdata[`BLA_F_BADDR_HI];
        if (reg_wdata[`BLA_B_UNLK])
          baddr_q[1:0] <= reg_wdata[`BLA_F_BADDR_LO];
        pmode_q <= reg_wdata[`BLA_F_PMODE];
        paddr_q <= reg_wdata[`BLA_F_PADDR];
      end
    end
  end

  // register read port, data valid one cycle after the strobe
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 32'h00000000;
    end else if (clk_en) begin
      rdata_q <= 32'h00000000;
      if (reg_rd && reg_addr == `BLA_OFS_CTRL)
        rdata_q <= {chain_q, offset_byte_count_sel_q, slave_id_wrap_increment_q, unlk_q, 5'h00,
                    baddr_q, pmode_q, paddr_q};
      if (reg_rd && reg_addr == `BLA_OFS_STAT) begin
        rdata_q[`BLA_B_BUSY] <= active;
        rdata_q[`BLA_B_DONE] <= (state_q == ST_DONE);
        rdata_q[`BLA_B_ERR] <= err_q;
        rdata_q[`BLA_F_DEV] <= dev_q;
        rdata_q[`BLA_F_ADDR] <= addr_q;
      end
    end
  end

  // re-address decision and engine request for the current phase
  always @* begin
    nxt_addr = addr_inc(addr_q, wpsize_q);
    wrap_one = ~wpsize_q & (addr_q[7:0] == 8'hFF);
    readdr = ((pmode_q != `BLA_PM_INF) &&
              ((nxt_addr & page_mask(pmode_q)) == 16'h0000)) |
             (wrap_one & wbinc_q);
    last_c = readdr | chain_pend_q | stop_pend_q;
    eng_cmd = `BLA_CMD_START;
    eng_tx = 8'h00;
    case (state_q)
      ST_DEVW: begin
        eng_cmd = `BLA_CMD_WR;
        eng_tx = {dev_q, 1'b0};
      end
      ST_AHI: begin
        eng_cmd = `BLA_CMD_WR;
        eng_tx = addr_q[15:8];
      end
      ST_ALO: begin
        eng_cmd = `BLA_CMD_WR;
        eng_tx = addr_q[7:0];
      end
      ST_DEVR: begin
        eng_cmd = `BLA_CMD_WR;
        eng_tx = {dev_q, 1'b1};
      end
      ST_READ: eng_cmd = `BLA_CMD_RD;
      ST_STOP: eng_cmd = `BLA_CMD_STOP;
      default: eng_cmd = `BLA_CMD_START;
    endcase
    eng_go = active & ~wait_q & ~eng_busy;
  end

  // boot sequencer
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      strap_cnt_q <= 2'h0;
      dev_q <= 7'h00;
      addr_q <= 16'h0000;
      wpsize_q <= 1'b0;
      wbinc_q <= 1'b0;
      wait_q <= 1'b0;
      last_q <= 1'b0;
      keep_q <= 1'b0;
      chain_pend_q <= 1'b0;
      stop_pend_q <= 1'b0;
      err_q <= 1'b0;
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
    end else if (clk_en) begin
      rx_valid_q <= 1'b0;
      // a new request in the take cycle is kept
      chain_pend_q <= chain_set | (chain_pend_q & ~chain_take);
      stop_pend_q <= stop_pend_q | (load_stop & active);
      if (eng_go) begin
        wait_q <= 1'b1;
        if (state_q == ST_READ) begin
          last_q <= last_c;
          keep_q <= ~(chain_pend_q | stop_pend_q);
        end
      end
      if (state_q == ST_IDLE) begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
        if (strap_take) begin
          dev_q <= {baddr_q[6:2], strap_s};
          addr_q <= start_addr(paddr_q, offset_byte_count_sel_q);
          wpsize_q <= offset_byte_count_sel_q;
          wbinc_q <= slave_id_wrap_increment_q;
          state_q <= ST_START;
        end
      end else if (eng_done) begin
        wait_q <= 1'b0;
        case (state_q)
          ST_START: state_q <= ST_DEVW;
          ST_DEVW: begin
            if (eng_rnack) begin
              err_q <= 1'b1;
              state_q <= ST_STOP;
            end else begin
              state_q <= wpsize_q ? ST_AHI : ST_ALO;
            end
          end
          ST_AHI: begin
            err_q <= err_q | eng_rnack;
            state_q <= eng_rnack ? ST_STOP : ST_ALO;
          end
          ST_ALO: begin
            err_q <= err_q | eng_rnack;
            state_q <= eng_rnack ? ST_STOP : ST_RSTRT;
          end
          ST_RSTRT: state_q <= ST_DEVR;
          ST_DEVR: begin
            err_q <= err_q | eng_rnack;
            state_q <= eng_rnack ? ST_STOP : ST_READ;
          end
          ST_READ: begin
            if (keep_q) begin
              rx_data_q <= eng_rx;
              rx_valid_q <= 1'b1;
              addr_q <= nxt_addr;
              if (wrap_one & wbinc_q)
                dev_q[2:0] <= dev_q[2:0] + 3'h1;
            end
            if (chain_take) begin
              // reload from the control word, then re-address
              dev_q <= baddr_q;
              addr_q <= start_addr(paddr_q, offset_byte_count_sel_q);
              wpsize_q <= offset_byte_count_sel_q;
              wbinc_q <= slave_id_wrap_increment_q;
              state_q <= ST_START;
            end else if (last_q && stop_pend_q) begin
              state_q <= ST_STOP;
            end else if (last_q) begin
              state_q <= ST_START;
            end
          end
          ST_STOP: state_q <= ST_DONE;
          default: state_q <= ST_DONE;
        endcase
      end
    end
  end

  // open-drain lines only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign reg_rdata = rdata_q;
  assign rx_data = rx_data_q;
  assign rx_valid = rx_valid_q;
  assign boot_busy = active;
  assign boot_done = (state_q == ST_DONE);
  assign boot_err = err_q;

endmodule

`default_nettype wire

// ===== verif/bla_top_monitor.sv
// Purpose: port checker for the boot loader addressing block
// Assumes: bench leaves one idle cycle between a write and a read
// Notes: bound to bla_top below
`timescale 1ns/1ns
`default_nettype none
`include "bla_map.vh"

module bla_top_monitor (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [1:0] slave_id_strap_pins,
  input wire logic rx_valid,
  input wire logic boot_busy,
  input wire logic boot_done,
  input wire logic scl_oe,
  input wire logic sda_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // control word strobes
  wire logic wc = reg_wr && reg_addr == `BLA_OFS_CTRL;
  wire logic rc = reg_rd && reg_addr == `BLA_OFS_CTRL;
  // register fields, boot start, byte pacing and end of boot
  property p_lock;
    wc && !reg_wdata[`BLA_B_UNLK] ##2 rc |=> reg_rdata[17:16] == $past(slave_id_strap_pins);
  endproperty
  a_lock: assert property (p_lock) else $error("strap bits moved while locked");
  property p_unlock;
    wc && reg_wdata[`BLA_B_UNLK] ##2 rc |=> reg_rdata[22:16] == $past(reg_wdata[22:16], 3);
  endproperty
  a_unlock: assert property (p_unlock) else $error("device address not written");
  property p_fields;
    wc ##2 rc |=> reg_rdata[15:0] == $past(reg_wdata[15:0], 3);
  endproperty
  a_fields: assert property (p_fields) else $error("page or start field lost");
  property p_boot_wait;
    $rose(rst_b) |-> (!scl_oe && !sda_oe) [*4];
  endproperty
  a_boot_wait: assert property (p_boot_wait) else $error("bus active before capture");
  property p_rx_gap;
    rx_valid |=> !rx_valid [*8];
  endproperty
  a_rx_gap: assert property (p_rx_gap) else $error("bytes too close");
  property p_excl;
    boot_done |-> !boot_busy && !scl_oe && !sda_oe;
  endproperty
  a_excl: assert property (p_excl) else $error("busy or lines held while done");
  property p_release;
    $rose(boot_done) |-> (!scl_oe && !sda_oe) [*8];
  endproperty
  a_release: assert property (p_release) else $error("lines held after done");
  property p_start;
    $rose(sda_oe) && !scl_oe |-> ##[1:60] scl_oe;
  endproperty
  a_start: assert property (p_start) else $error("start not followed by clock");
endmodule

bind bla_top bla_top_monitor u_mon (
  .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .slave_id_strap_pins(slave_id_strap_pins), .rx_valid(rx_valid), .boot_busy(boot_busy),
  .boot_done(boot_done), .scl_oe(scl_oe), .sda_oe(sda_oe)
);
`default_nettype wire

// ===== verif/bla_eeprom_model.sv
// Purpose: behavioural serial EEPROM holding the boot image
// Assumes: open-drain lines with pull-ups; answers any device address
// Notes: slow holds the clock low after each falling edge
`timescale 1ns/1ns
`default_nettype none

module bla_eeprom_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic slow,
  input wire logic two,
  output logic scl_pull,
  output logic sda_pull
);
  logic [7:0] sh = 8'h00;
  logic [7:0] q = 8'h00;
  logic [6:0] rdev = 7'h00;
  logic [15:0] ptr = 16'h0000;
  logic [15:0] rofs = 16'h0000;
  logic act = 1'b0;
  logic rd = 1'b0;
  logic rd_pend = 1'b0;
  logic mnack = 1'b0;
  int bits = 0;
  int nbyte = 0;
  int naddr = 0;
  int nnack = 0;
  initial scl_pull = 1'b0;
  initial sda_pull = 1'b0;
  // image content, set by the low three device address bits and the offset
  function automatic logic [7:0] mem_byte(input logic [6:0] d, input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ {d[2:0], 5'h00};
  endfunction
  // start condition opens a frame
  always @(negedge sda) if (scl) begin
    act = 1'b1;
    bits = 0;
    nbyte = 0;
    rd = 1'b0;
    rd_pend = 1'b0;
    mnack = 1'b0;
  end
  // stop condition closes it
  always @(posedge sda) if (scl) act = 1'b0;
  // shift in data, note the master's acknowledge
  always @(posedge scl) if (act) begin
    if (bits < 8) sh = {sh[6:0], sda};
    else if (rd) begin
      mnack = sda;
      if (sda) nnack++;
    end
    bits++;
  end
  // acknowledge writes, shift out read data
  always @(negedge scl) if (act) begin
    if (bits == 8 && !rd) begin
      if (nbyte == 0 && !sh[0]) naddr++;
      if (nbyte == 0 && sh[0]) begin
        rd_pend = 1'b1;
        rdev = sh[7:1];
        rofs = ptr;
      end
      if (nbyte == 1) ptr = two ? {sh, 8'h00} : {8'h00, sh};
      if (nbyte == 2) ptr[7:0] = sh;
      sda_pull = 1'b1;
    end else if (bits == 8) sda_pull = 1'b0;
    else if (bits == 9) begin
      bits = 0;
      nbyte++;
      rd = rd | rd_pend;
      if (rd && !mnack) begin
        q = mem_byte(rdev, ptr);
        ptr = ptr + 16'h0001;
      end
      sda_pull = rd && !mnack && !q[7];
    end else if (rd && !mnack) sda_pull = !q[7 - bits];
  end
  // slow answer: stretch the low clock phase
  always @(negedge scl) if (act && slow) begin
    scl_pull = 1'b1;
    #7000 scl_pull = 1'b0;
  end
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Purpose: bench for the boot loader addressing block
// Assumes: straps tied to 2'b10, clk_en held high
// Notes: boot runs once through default, paged, chained and wrap reads
`timescale 1ns/1ns
`default_nettype none
`include "bla_map.vh"

module tb;
  localparam logic [6:0] dev0 = {`BLA_RST_BADDR_HI, 2'b10};
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic load_cnt_zero = 1'b0;
  logic load_stop = 1'b0;
  logic slow = 1'b1;
  logic two = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic [31:0] v, w, c;
  logic [7:0] b;
  int fails = 0;
  int comparisons = 0;
  wire logic [31:0] reg_rdata;
  wire logic [7:0] rx_data;
  wire logic rx_valid, boot_busy, boot_done, boot_err, scl_out, scl_oe, sda_out, sda_oe;
  wire logic scl_pull, sda_pull;
  // open-drain lines with pull-ups
  wire logic scl_w = (scl_oe ? scl_out : 1'b1) && !scl_pull;
  wire logic sda_w = (sda_oe ? sda_out : 1'b1) && !sda_pull;

  bla_top dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .slave_id_strap_pins(2'b10), .load_cnt_zero(load_cnt_zero), .load_stop(load_stop),
    .rx_data(rx_data), .rx_valid(rx_valid), .boot_busy(boot_busy), .boot_done(boot_done),
    .boot_err(boot_err), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe)
  );
  bla_eeprom_model u_mem (
    .scl(scl_w), .sda(sda_w), .slow(slow), .two(two), .scl_pull(scl_pull), .sda_pull(sda_pull)
  );

  always #50 sys_clk = ~sys_clk;

  // verdict
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // register bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // next delivered byte, bounded wait
  task automatic get_byte(output logic [7:0] d);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (rx_valid !== 1'b1 && n < 8000);
    d = rx_data;
    if (n >= 8000) begin
      fails++;
      conclude();
    end
  endtask
  task automatic expect_byte(input logic [6:0] d, input logic [15:0] a);
    get_byte(b);
    chk("rx byte", {24'h0, b}, {24'h0, u_mem.mem_byte(d, a)});
  endtask
  // read on, at most four bytes, until the memory is addressed anew
  task automatic skip_to(input int n);
    for (int k = 0; k < 4 && u_mem.naddr < n; k++) get_byte(b);
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge sys_clk);
    // reset value and unmapped hole
    rd(`BLA_OFS_CTRL, v);
    w = {1'b0, `BLA_RST_OFFSET_BYTE_COUNT_SEL, `BLA_RST_SLAVE_ID_WRAP_INCREMENT, 6'h00, dev0, `BLA_RST_PMODE, `BLA_RST_PADDR};
    chk("ctrl reset", v, w);
    rd(8'h08, v);
    chk("unmapped", v, 32'h00000000);
    $display("test reset done");
    // default mode: eight bytes then re-address
    for (int i = 0; i < 9; i++) expect_byte(dev0, i);
    chk("device", u_mem.rdev, dev0);
    chk("addr phases", u_mem.naddr, 2);
    chk("nacks", u_mem.nnack, 1);
    chk("restart offset", u_mem.rofs, 32'h8);
    $display("test default done");
    // lock, unlock, page mode change at once
    slow <= 1'b0;
    w = {3'b001, 1'b0, 5'h00, 5'h0B, 2'b01, 3'h1, 13'h0000};
    wr(`BLA_OFS_CTRL, w);
    rd(`BLA_OFS_CTRL, v);
    chk("locked", v, {w[31:18], 2'b10, w[15:0]});
    wr(`BLA_OFS_CTRL, w | 32'h10000000);
    rd(`BLA_OFS_CTRL, v);
    chk("unlocked", v[22:16], w[22:16]);
    for (int i = 9; i < 33; i++) expect_byte(dev0, i);
    chk("addr phases", u_mem.naddr, 3);
    chk("page offset", u_mem.rofs, 32'h20);
    chk("old device", u_mem.rdev, dev0);
    $display("test page done");
    // chain refused with a nonzero count, then taken
    c = {4'b1101, 5'h00, 7'h2D, 3'h7, 13'h0127};
    wr(`BLA_OFS_CTRL, c);
    expect_byte(dev0, 33);
    expect_byte(dev0, 34);
    chk("no chain", u_mem.naddr, 3);
    @(posedge sys_clk) load_cnt_zero <= 1'b1;
    two <= 1'b1;
    wr(`BLA_OFS_CTRL, c);
    skip_to(4);
    @(posedge sys_clk) load_cnt_zero <= 1'b0;
    chk("chain device", u_mem.rdev, 7'h2D);
    chk("chain offset", u_mem.rofs, 32'h0938);
    chk("chain byte", b, u_mem.mem_byte(7'h2D, 16'h0938));
    for (int i = 1; i < 9; i++) expect_byte(7'h2D, 16'h0938 + i);
    chk("infinite", u_mem.naddr, 4);
    $display("test chain done");
    // one-byte offset wraps into the next device
    c = {4'b1011, 5'h00, 7'h2D, 3'h7, 13'h1FFF};
    @(posedge sys_clk) load_cnt_zero <= 1'b1;
    two <= 1'b0;
    wr(`BLA_OFS_CTRL, c);
    skip_to(5);
    @(posedge sys_clk) load_cnt_zero <= 1'b0;
    chk("short offset", u_mem.rofs, 32'hF8);
    chk("short byte", b, u_mem.mem_byte(7'h2D, 16'h00F8));
    for (int i = 16'h00F9; i < 16'h0100; i++) expect_byte(7'h2D, i);
    expect_byte(7'h2E, 16'h0000);
    chk("wrap device", u_mem.rdev, 7'h2E);
    chk("wrap offset", u_mem.rofs, 32'h0);
    $display("test wrap done");
    // end of image
    @(posedge sys_clk) load_stop <= 1'b1;
    for (int n = 0; n < 5000 && boot_done !== 1'b1; n++) @(posedge sys_clk);
    // end of boot never seen: count it and report
    if (boot_done !== 1'b1) begin
      fails++;
      conclude();
    end
    load_stop <= 1'b0;
    repeat (20) @(posedge sys_clk);
    chk("lines free", {scl_w, sda_w}, 2'b11);
    rd(`BLA_OFS_STAT, v);
    chk("status", v[31:29], 3'b010);
    chk("no error", boot_err, 1'b0);
    $display("test stop done");
    conclude();
  end
endmodule
`default_nettype wire
